/* intr_prio_regs.vh */
// Constants of the interrupt priority and vector block.
// Included by the interrupt vector and priority design file; definitions only.
`ifndef INTR_PRIO_REGS_VH
`define INTR_PRIO_REGS_VH
`define PRIO_LOW_ADDR        8'hB8
`define PRIO_HIGH_ADDR       8'hB7
`define INTR_MASK_ADDR       8'hA8
`define INTR_STATUS_ADDR     8'hA9
`define CTRL_ADDR            8'hAA
`define VECTOR_ADDR_LO       8'hAB
`define VECTOR_ADDR_HI       8'hAC
`define PRIO_LOW_RESET       8'h00
`define PRIO_HIGH_RESET      8'h00
`define INTR_MASK_RESET      8'h00
`define PRIO_LOW_WMASK       8'h7F
`define NUM_SOURCES          10
`define VEC_RESET            16'h0000
`define VEC_FIRST_EXT        16'h0003
`define VEC_FIRST_TIMER      16'h000B
`define VEC_SECOND_EXT       16'h0013
`define VEC_SECOND_TIMER     16'h001B
`define VEC_SERIAL_PORT      16'h0023
`define VEC_THIRD_TIMER      16'h002B
`define VEC_COUNTER_ARRAY    16'h0033
`define VEC_KEYBOARD         16'h003B
`define VEC_SERIAL_PERIPH    16'h004B
`define CTRL_ENABLE_BIT      0
`define STAT_TAKEN_BIT       0
`define STAT_PREEMPT_BIT     1
`define STAT_RETURN_BIT      2
`endif

/* prio_select.v */
// Combinational pick of the winning source among pending requests.
// Inputs are polling-ordered; index 0 polls first.
`timescale 1ns/1ps
module prio_select #(
  parameter N = 10
) (
  input  wire [N-1:0]   req,
  input  wire [2*N-1:0] level,
  output reg            found,
  output reg  [3:0]     winner,
  output reg  [1:0]     winLevel
);
  integer i;
  // Strictly higher level replaces; equal level keeps earlier poll
  always @* begin
    found    = 1'b0;
    winner   = 4'h0;
    winLevel = 2'b00;
    for (i = 0; i < N; i = i + 1) begin
      if (req[i] && (!found || level[2*i +: 2] > winLevel)) begin
        found    = 1'b1;
        winner   = i[3:0];
        winLevel = level[2*i +: 2];
      end
    end
  end
endmodule

/* interrupt_vector_priority.v */
// Interrupt source mapping, polling order and priority levels for the core.
// Assumes request flags are synchronous to clk; the core pulses ackTaken
// when it fetches vectorAddr and handlerReturn on return from a handler.
//
// Summary of operation
// - Reset is source zero, vector 0000h.
// - Serial port from receive or transmit, 0023h.
// - Third timer from overflow or external, 002Bh.
// - Counter array from overflow or modules, 0033h.
// - Keyboard 003Bh, serial peripheral 004Bh.
// - Fixed polling order breaks same-level ties.
// - Low priority register at B8h, bit layout.
// - Low and high bits form level for sources 1 to 7; keyboard and serial peripheral fixed lowest.
// - Reset clears bits; bit writes allowed.
`timescale 1ns/1ps
`include "intr_prio_regs.vh"
module interrupt_vector_priority (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  addr,
  input  wire [7:0]  wrData,
  input  wire        wrStrobe,
  input  wire        rdStrobe,
  output reg  [7:0]  rdData,
  input  wire        first_ext_request_flag,
  input  wire        first_timer_overflow_flag,
  input  wire        second_ext_request_flag,
  input  wire        second_timer_overflow_flag,
  input  wire        receive_complete_flag,
  input  wire        transmit_complete_flag,
  input  wire        third_timer_overflow_flag,
  input  wire        third_timer_external_flag,
  input  wire        counter_array_overflow_flag,
  input  wire [4:0]  module_compare_capture_flag,
  input  wire        keyboard_interrupt_flag,
  input  wire        serial_peripheral_interrupt_flag,
  input  wire        ackTaken,
  input  wire        handlerReturn,
  output reg         intRequest,
  output reg  [15:0] vectorAddr,
  output reg  [3:0]  sourceNumber,
  output reg         resetVector,
  output reg         irq
);
  localparam N = `NUM_SOURCES;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] interrupt_priority_low;
  reg [7:0] prioHigh;
  reg [2:0] intrMask;
  reg [2:0] intrStatus;
  reg       enable;
  reg [1:0] state;
  reg [1:0] stackLevel0;
  reg [1:0] stackLevel1;
  reg [1:0] stackLevel2;
  reg [1:0] stackLevel3;
  reg [2:0] depth;
  reg       resetPending;

  wire [1:0] curLevel = (depth == 3'd0) ? 2'b00 : stackLevel0;

  // Sources in polling order: rst, ext1, tmr1, ext2, tmr2, pca, uart, tmr3, kbd, spi
  wire serialReq  = receive_complete_flag | transmit_complete_flag;
  wire timer3Req  = third_timer_overflow_flag | third_timer_external_flag;
  wire counterReq = counter_array_overflow_flag | (|module_compare_capture_flag);

  // Source number per polling slot
  function [3:0] slotSource;
    input [3:0] slot;
    begin
      case (slot)
        4'd5:    slotSource = 4'd7;
        4'd6:    slotSource = 4'd5;
        4'd7:    slotSource = 4'd6;
        default: slotSource = slot;
      endcase
    end
  endfunction

  // Vector per source number
  function [15:0] sourceVector;
    input [3:0] src;
    begin
      case (src)
        4'd0:    sourceVector = `VEC_RESET;
        4'd1:    sourceVector = `VEC_FIRST_EXT;
        4'd2:    sourceVector = `VEC_FIRST_TIMER;
        4'd3:    sourceVector = `VEC_SECOND_EXT;
        4'd4:    sourceVector = `VEC_SECOND_TIMER;
        4'd5:    sourceVector = `VEC_SERIAL_PORT;
        4'd6:    sourceVector = `VEC_THIRD_TIMER;
        4'd7:    sourceVector = `VEC_COUNTER_ARRAY;
        4'd8:    sourceVector = `VEC_KEYBOARD;
        4'd9:    sourceVector = `VEC_SERIAL_PERIPH;
        default: sourceVector = `VEC_RESET;
      endcase
    end
  endfunction

  wire [N-1:0] reqSlot = {serial_peripheral_interrupt_flag, keyboard_interrupt_flag,
                          timer3Req, serialReq, counterReq, second_timer_overflow_flag,
                          second_ext_request_flag, first_timer_overflow_flag,
                          first_ext_request_flag, resetPending};

  ////////////////////////////////////////////////////////////////////////////
  // Levels per polling slot
  // high and low bits combine
  wire [1:0] lvExt1  = {prioHigh[0], interrupt_priority_low[0]};
  wire [1:0] lvTmr1  = {prioHigh[1], interrupt_priority_low[1]};
  wire [1:0] lvExt2  = {prioHigh[2], interrupt_priority_low[2]};
  wire [1:0] lvTmr2  = {prioHigh[3], interrupt_priority_low[3]};
  wire [1:0] lvSer   = {prioHigh[4], interrupt_priority_low[4]};
  wire [1:0] lvTmr3  = {prioHigh[5], interrupt_priority_low[5]};
  wire [1:0] lvPca   = {prioHigh[6], interrupt_priority_low[6]};
  // Reset always tops; keyboard and peripheral use fixed lowest level
  wire [2*N-1:0] slotLevel = {2'b00, 2'b00, lvTmr3, lvSer, lvPca, lvTmr2,
                              lvExt2, lvTmr1, lvExt1, 2'b11};

  wire       found;
  wire [3:0] winSlot;
  wire [1:0] winLevel;

  prio_select #(
    .N (N)
  ) u_select (
    .req      (reqSlot),
    .level    (slotLevel),
    .found    (found),
    .winner   (winSlot),
    .winLevel (winLevel)
  );

  wire canTake = found && (resetPending || (enable && (depth == 3'd0 ||
                 (winLevel > curLevel && depth < 3'd4))));

  wire [3:0] winSrc = slotSource(winSlot);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  wire wrLow  = wrStrobe && (addr == `PRIO_LOW_ADDR);
  wire wrHigh = wrStrobe && (addr == `PRIO_HIGH_ADDR);
  wire wrMask = wrStrobe && (addr == `INTR_MASK_ADDR);
  wire wrCtrl = wrStrobe && (addr == `CTRL_ADDR);
  wire rdStat = rdStrobe && (addr == `INTR_STATUS_ADDR);

  wire takeNow   = intRequest && ackTaken;
  wire returnNow = handlerReturn && (depth != 3'd0);
  // A non-reset fetch pushes one handler level onto the nesting stack
  wire pushNow   = (state == ST_RUN) && ackTaken && !resetVector;
  wire [2:0] events = {returnNow, takeNow && (depth != 3'd0), takeNow};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_priority_low <= `PRIO_LOW_RESET;
      prioHigh               <= `PRIO_HIGH_RESET;
      intrMask               <= 3'b000;
      enable                 <= 1'b0;
    end else begin
      if (wrLow)
        interrupt_priority_low <= wrData & `PRIO_LOW_WMASK;
      if (wrHigh)
        prioHigh <= wrData & `PRIO_LOW_WMASK;
      if (wrMask)
        intrMask <= wrData[2:0];
      if (wrCtrl)
        enable <= wrData[`CTRL_ENABLE_BIT];
    end
  end

  // Sticky status; a new event beats the read clear
  always @(posedge clk or posedge rst) begin
    if (rst)
      intrStatus <= 3'b000;
    else if (rdStat)
      intrStatus <= events;
    else
      intrStatus <= intrStatus | events;
  end

  always @(posedge clk or posedge rst) begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(((rdStat ? 3'b000 : intrStatus) | events) & intrMask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request and handler nesting
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state        <= ST_IDLE;
      intRequest   <= 1'b0;
      vectorAddr   <= `VEC_RESET;
      sourceNumber <= 4'h0;
      resetVector  <= 1'b0;
      resetPending <= 1'b1;
      depth        <= 3'd0;
      stackLevel0  <= 2'b00;
      stackLevel1  <= 2'b00;
      stackLevel2  <= 2'b00;
      stackLevel3  <= 2'b00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (canTake) begin
            intRequest   <= 1'b1;
            vectorAddr   <= sourceVector(winSrc);
            sourceNumber <= winSrc;
            resetVector  <= (winSrc == 4'd0);
            state        <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (ackTaken) begin
            intRequest <= 1'b0;
            state      <= ST_IDLE;
            if (resetVector) begin
              resetPending <= 1'b0;
            end else begin
              depth       <= depth + 3'd1;
              stackLevel0 <= slotLevel[2*slotOf(sourceNumber) +: 2];
              stackLevel1 <= stackLevel0;
              stackLevel2 <= stackLevel1;
              stackLevel3 <= stackLevel2;
            end
          end
        end
        default: begin
          state      <= ST_IDLE;
          intRequest <= 1'b0;
        end
      endcase
      // return and fetch may share one edge
      // Dropping either would leave depth out of step with the core, so a
      // shared edge pops the old top and pushes the new level in its place
      if (returnNow) begin
        if (pushNow) begin
          depth       <= depth;
          stackLevel1 <= stackLevel1;
          stackLevel2 <= stackLevel2;
          stackLevel3 <= stackLevel3;
        end else begin
          depth       <= depth - 3'd1;
          stackLevel0 <= stackLevel1;
          stackLevel1 <= stackLevel2;
          stackLevel2 <= stackLevel3;
          stackLevel3 <= 2'b00;
        end
      end
    end
  end

  // Polling slot of a source number
  function [3:0] slotOf;
    input [3:0] src;
    begin
      case (src)
        4'd5:    slotOf = 4'd6;
        4'd6:    slotOf = 4'd7;
        4'd7:    slotOf = 4'd5;
        default: slotOf = src;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always @(posedge clk or posedge rst) begin
    if (rst)
      rdData <= 8'h00;
    else if (rdStrobe) begin
      case (addr)
        `PRIO_LOW_ADDR:     rdData <= interrupt_priority_low;
        `PRIO_HIGH_ADDR:    rdData <= prioHigh;
        `INTR_MASK_ADDR:    rdData <= {5'b00000, intrMask};
        `INTR_STATUS_ADDR:  rdData <= {5'b00000, intrStatus};
        `CTRL_ADDR:         rdData <= {depth, 4'h0, enable};
        `VECTOR_ADDR_LO:    rdData <= vectorAddr[7:0];
        `VECTOR_ADDR_HI:    rdData <= vectorAddr[15:8];
        default:            rdData <= 8'h00;
      endcase
    end else
      rdData <= 8'h00;
  end
endmodule

/* core_model.sv */
// Behavioural core: fetches each requested vector and returns from handlers.
// Assumes intRequest stands until the ack edge, as the block promises.
`timescale 1ns/1ps
module core_model (
  input  logic       clk,
  input  logic       rst,
  input  logic       intRequest,
  input  logic [3:0] ackDelay,
  input  logic [7:0] retDelay,
  output logic       ackTaken,
  output logic       handlerReturn
);
  logic [3:0] waitCnt;
  logic [7:0] retCnt;
  logic [2:0] open;
  ////////////////////////////////////////////////////////////////////////////
  // One ack per request, then one return per open handler; a long retDelay
  // keeps a handler running so that nesting can be provoked
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ackTaken      <= 1'b0;
      handlerReturn <= 1'b0;
      waitCnt       <= 4'h0;
      retCnt        <= 8'h00;
      open          <= 3'h0;
    end else begin
      ackTaken      <= 1'b0;
      handlerReturn <= 1'b0;
      open          <= open + {2'b00, ackTaken} - {2'b00, handlerReturn};
      if (intRequest && !ackTaken) begin
        waitCnt  <= (waitCnt >= ackDelay) ? 4'h0 : waitCnt + 4'h1;
        ackTaken <= (waitCnt >= ackDelay);
      end
      if (open != 3'h0 && !handlerReturn) begin
        retCnt        <= (retCnt >= retDelay) ? 8'h00 : retCnt + 8'h01;
        handlerReturn <= (retCnt >= retDelay);
      end
    end
  end
endmodule

/* interrupt_vector_priority_assertions.sv */
// Checker for the interrupt vector and priority block, bound to its ports.
// Assumes ackTaken comes only while intRequest stands.
`timescale 1ns/1ps
module interrupt_vector_priority_assertions (
  input logic        clk,
  input logic        rst,
  input logic [7:0]  addr,
  input logic [7:0]  wrData,
  input logic        wrStrobe,
  input logic        rdStrobe,
  input logic [7:0]  rdData,
  input logic        receive_complete_flag,
  input logic        transmit_complete_flag,
  input logic        third_timer_overflow_flag,
  input logic        third_timer_external_flag,
  input logic        counter_array_overflow_flag,
  input logic [4:0]  module_compare_capture_flag,
  input logic        ackTaken,
  input logic        intRequest,
  input logic [15:0] vectorAddr,
  input logic [3:0]  sourceNumber,
  input logic        resetVector
);
  localparam logic [15:0] VECS [0:9] = '{16'h0000, 16'h0003, 16'h000B, 16'h0013,
    16'h001B, 16'h0023, 16'h002B, 16'h0033, 16'h003B, 16'h004B};
  logic [7:0] lowPrio;
  logic [7:0] highPrio;
  wire        pcaReq = counter_array_overflow_flag | (|module_compare_capture_flag);
  wire  [2:0] causeReq = {pcaReq, third_timer_overflow_flag | third_timer_external_flag,
                          receive_complete_flag | transmit_complete_flag};
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of what software wrote; bit 7 never sticks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lowPrio  <= 8'h00;
      highPrio <= 8'h00;
    end else if (wrStrobe && addr == 8'hB8) begin
      lowPrio <= wrData & 8'h7F;
    end else if (wrStrobe && addr == 8'hB7) begin
      highPrio <= wrData & 8'h7F;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence prioRead;
    rdStrobe && addr == 8'hB8;
  endsequence
  sequence requestAcked;
    intRequest && ackTaken;
  endsequence
  reset_vector_a: assert property ($fell(rst) |=> intRequest && resetVector
    && vectorAddr == 16'h0000 && sourceNumber == 4'h0) else $error("reset vector missing");
  vector_map_a: assert property (intRequest |-> vectorAddr == VECS[sourceNumber])
    else $error("vector does not match source");
  request_cause_a: assert property ($rose(intRequest) && sourceNumber >= 4'h5
    && sourceNumber <= 4'h7 |-> (($past(causeReq) >> (sourceNumber - 4'h5)) & 3'b001) != 3'b000)
    else $error("request without its flags");
  poll_order_a: assert property ($rose(intRequest) && sourceNumber == 4'h5 && $past(pcaReq)
    |-> {highPrio[4], lowPrio[4]} > {highPrio[6], lowPrio[6]}) else $error("poll order broken");
  request_hold_a: assert property (intRequest && !ackTaken |=> intRequest && $stable(vectorAddr))
    else $error("request dropped before ack");
  ack_release_a: assert property (requestAcked |=> !intRequest) else $error("request kept");
  prio_readback_a: assert property (prioRead |=> rdData == lowPrio)
    else $error("priority readback wrong");
  read_idle_a: assert property (!$past(rdStrobe) |-> rdData == 8'h00)
    else $error("read data outside read");
endmodule
bind interrupt_vector_priority interrupt_vector_priority_assertions u_chk (.*);

/* interrupt_vector_priority_test.sv */
// Self-checking bench for the interrupt vector and priority block.
// Assumes core_model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module interrupt_vector_priority_test;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [7:0]  wrData;
  logic        wrStrobe;
  logic        rdStrobe;
  logic        ackTaken;
  logic        handlerReturn;
  logic [3:0]  ackDelay;
  logic [7:0]  retDelay;
  logic [15:0] fl;
  logic [7:0]  got;
  int          miscompares;
  int          cmp_count;
  wire  [7:0]  rdData;
  wire  [15:0] vectorAddr;
  wire  [3:0]  sourceNumber;
  wire         intRequest, resetVector, irq;
  wire         first_ext_request_flag, first_timer_overflow_flag, second_ext_request_flag;
  wire         second_timer_overflow_flag, receive_complete_flag, transmit_complete_flag;
  wire         third_timer_overflow_flag, third_timer_external_flag;
  wire         counter_array_overflow_flag, keyboard_interrupt_flag;
  wire         serial_peripheral_interrupt_flag;
  wire  [4:0]  module_compare_capture_flag;
  localparam logic [15:0] VECS [0:9] = '{16'h0000, 16'h0003, 16'h000B, 16'h0013,
    16'h001B, 16'h0023, 16'h002B, 16'h0033, 16'h003B, 16'h004B};
  localparam logic [3:0] SRC [0:15] = '{1, 2, 3, 4, 5, 5, 6, 6, 7, 7, 7, 7, 7, 7, 8, 9};
  assign {serial_peripheral_interrupt_flag, keyboard_interrupt_flag, module_compare_capture_flag,
    counter_array_overflow_flag, third_timer_external_flag, third_timer_overflow_flag,
    transmit_complete_flag, receive_complete_flag, second_timer_overflow_flag,
    second_ext_request_flag, first_timer_overflow_flag, first_ext_request_flag} = fl;
  interrupt_vector_priority u_interrupt_vector_priority (.*);
  core_model u_core_model (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wrStrobe <= 1'b1;
    addr     <= a;
    wrData   <= d;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rdStrobe <= 1'b1;
    addr     <= a;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 got = rdData;
  endtask
  // Raise flags once idle; lim bounds the wait, so a short one proves preemption
  task automatic fire(input logic [15:0] f, input logic [3:0] es, input int lim);
    int n;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (intRequest !== 1'b0 && n < 200);
    @(posedge clk);
    fl <= f;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (intRequest !== 1'b1 && n < lim);
    chk("intRequest", 16'h0001, {15'h0000, intRequest});
    chk("vectorAddr", VECS[es], vectorAddr);
    chk("sourceNumber", {12'h000, es}, {12'h000, sourceNumber});
    @(posedge clk);
    fl <= 16'h0000;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    {rst, addr, wrData, wrStrobe, rdStrobe, fl} = {1'b1, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0000};
    ackDelay = 4'h3;
    retDelay = 8'h05;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("resetVector", 16'h0001, {15'h0000, resetVector});
    chk("vectorAddr", 16'h0000, vectorAddr);
    $display("test reset vector done");
    rd(8'hB8);
    chk("prioLow", 16'h0000, {8'h00, got});
    wr(8'hB8, 8'hFF);
    rd(8'hB8);
    chk("prioLow", 16'h007F, {8'h00, got});
    rd(8'hBA);
    chk("unmapped", 16'h0000, {8'h00, got});
    wr(8'hB8, 8'h00);
    wr(8'hAA, 8'h01);
    rd(8'hA9);
    wr(8'hA8, 8'h01);
    $display("test registers done");
    for (int i = 0; i < 16; i++) fire(16'h0001 << i, SRC[i], 200);
    $display("test source vectors done");
    fire(16'h0110, 4'h7, 200);
    wr(8'hB8, 8'h10);
    fire(16'h0110, 4'h5, 200);
    $display("test polling and levels done");
    @(posedge clk);
    retDelay <= 8'h30;
    fire(16'h0001, 4'h1, 200);
    fire(16'h0010, 4'h5, 10);
    $display("test preemption done");
    @(posedge clk);
    #1 chk("irq", 16'h0001, {15'h0000, irq});
    wr(8'hA8, 8'h00);
    @(posedge clk);
    #1 chk("irqMasked", 16'h0000, {15'h0000, irq});
    wr(8'hA8, 8'h01);
    rd(8'hA9);
    chk("statusTaken", 16'h0001, {15'h0000, got[0]});
    @(posedge clk);
    #1 chk("irqCleared", 16'h0000, {15'h0000, irq});
    $display("test interrupt status done");
    wr(8'hB7, 8'hFF);
    rd(8'hB7);
    chk("prioHigh", 16'h007F, {8'h00, got});
    rd(8'hAB);
    chk("vectorLow", 16'h0023, {8'h00, got});
    rd(8'hAC);
    chk("vectorHigh", 16'h0000, {8'h00, got});
    $display("test readback done");
    tally_and_finish;
  end
endmodule
